// *** lpmcfg_pkg.sv ***
// Shared constants, types and decoders of the low-power polling configuration block.
package lpmcfg_pkg;

	// ==========================================================
	// Frame layout
	localparam int FRAME_W     = 32;
	localparam int ADDR_W      = 7;
	localparam int ADDR_MSB    = 31;
	localparam int ADDR_LSB    = 25;
	localparam int RW_BIT      = 24;
	localparam int DATA_MSB    = 23;
	localparam int FAULT_BIT   = 23;
	localparam int INTF_BIT    = 22;
	localparam int PAYLOAD_W   = 22;
	localparam int BITCNT_W    = 6;
	localparam logic [5:0] BITCNT_FULL = 6'h20;
	localparam logic [5:0] BITCNT_LAST = 6'h1F;
	localparam logic       RW_WRITE    = 1'b1;

	// ==========================================================
	// Register addresses
	localparam logic [6:0] ADDR_POLL_CUR_PROG = 7'h16;
	localparam logic [6:0] ADDR_POLL_CUR_GND  = 7'h17;
	localparam logic [6:0] ADDR_SLOW_POLL_PROG = 7'h18;

	// ==========================================================
	// Channel counts and reset values
	localparam int PROG_CH = 8;
	localparam int GND_CH  = 14;
	localparam logic [7:0]  RST_POLL_CUR_PROG  = 8'h00;
	localparam logic [13:0] RST_POLL_CUR_GND   = 14'h0000;
	localparam logic [7:0]  RST_SLOW_POLL_PROG = 8'h00;

	// ==========================================================
	// Polling currents in units of 0.1 mA
	localparam int         WET_CODE_W       = 3;
	localparam int         CUR_W            = 8;
	localparam logic [7:0] CUR_DEFAULT_BATT = 8'h16;
	localparam logic [7:0] CUR_DEFAULT_GND  = 8'h0A;

	// ==========================================================
	// Slow polling divides the normal tick by four
	localparam int         SLOW_CNT_W = 2;
	localparam logic [1:0] SLOW_PHASE = 2'h0;

	typedef enum logic {LPMCFG_IDLE, LPMCFG_EXEC} lpmcfg_state_t;

	// Converts a wetting current level code into polling current units.
	function automatic logic [7:0] wet_units(input logic [2:0] code);
		case (code)
			3'h0:    wet_units = 8'h14;
			3'h1:    wet_units = 8'h3C;
			3'h2:    wet_units = 8'h50;
			3'h3:    wet_units = 8'h64;
			3'h4:    wet_units = 8'h78;
			3'h5:    wet_units = 8'h8C;
			3'h6:    wet_units = 8'hA0;
			default: wet_units = 8'hC8;
		endcase
	endfunction : wet_units

endpackage : lpmcfg_pkg

// *** lpmcfg_if.sv ***
// Carrier between the serial link end and the register core.
interface lpmcfg_if;
	logic [31:0] frame;
	logic        req_tgl;
	logic [31:0] reply;

	modport link
	(
		output frame,
		output req_tgl,
		input  reply
	);

	modport core
	(
		input  frame,
		input  req_tgl,
		output reply
	);
endinterface : lpmcfg_if

// *** lpmcfg_spi_link.sv ***
// Serial frame shifter running on the serial clock.
module lpmcfg_spi_link
(
	input  wire logic sclk,
	input  wire logic rst,
	input  wire logic cs_n,
	input  wire logic mosi,
	output logic      miso,
	output logic      miso_oe,
	lpmcfg_if.link    bus
);

	typedef struct packed {
		logic [31:0] shift;
		logic [31:0] frame;
		logic        tgl;
	} lpmcfg_link_t;

	lpmcfg_link_t s_q;
	lpmcfg_link_t s_d;
	logic [5:0]   bit_cnt_q;
	logic         cnt_clr;

	// ==========================================================
	// Bit counter, cleared while the chip select is idle.
	assign cnt_clr = rst | cs_n;

	always_ff @(posedge sclk or posedge cnt_clr)
	begin
		if (cnt_clr)
			bit_cnt_q <= 6'h00;
		else
			bit_cnt_q <= (bit_cnt_q == lpmcfg_pkg::BITCNT_FULL) ? bit_cnt_q : bit_cnt_q + 6'h01;
	end

	// ==========================================================
	// Shifter; the 32nd bit completes the frame and flips the request toggle.
	always_comb
	begin
		s_d = s_q;
		if (!cs_n)
		begin
			s_d.shift = {s_q.shift[30:0], mosi};
			if (bit_cnt_q == lpmcfg_pkg::BITCNT_LAST)
			begin
				s_d.frame = {s_q.shift[30:0], mosi};
				s_d.tgl   = ~s_q.tgl;
			end
		end
	end

	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign bus.frame   = s_q.frame;
	assign bus.req_tgl = s_q.tgl;

	// ==========================================================
	// Reply bits leave most significant first, one per rising edge.
	always_comb
	begin
		if (bit_cnt_q == lpmcfg_pkg::BITCNT_FULL)
			miso = 1'b0;
		else
			miso = bus.reply[~bit_cnt_q[4:0]];
	end

	assign miso_oe = ~cs_n;

endmodule : lpmcfg_spi_link

// *** lpmcfg_regs.sv ***
// Low-power polling configuration registers with serial access and polling control.
module lpmcfg_regs
(
	input  wire logic                                   CLOCK,
	input  wire logic                                   RST,
	input  wire logic                                   SCLK,
	input  wire logic                                   CS_B,
	input  wire logic                                   MOSI,
	output logic                                        MISO,
	output logic                                        MISO_OE,
	input  wire logic                                   FAULT_STATUS,
	input  wire logic                                   INTERRUPT_FLAG,
	input  wire logic                                   LOW_POWER_STATE,
	input  wire logic                                   NORMAL_POLL_TICK,
	input  wire logic [lpmcfg_pkg::PROG_CH-1:0]         BATTERY_SWITCH_CONFIG,
	input  wire logic [lpmcfg_pkg::PROG_CH*3-1:0]       WETTING_LEVEL_PROG,
	input  wire logic [lpmcfg_pkg::GND_CH*3-1:0]        WETTING_LEVEL_GND,
	output logic [lpmcfg_pkg::PROG_CH*8-1:0]            PROG_POLL_CURRENT,
	output logic [lpmcfg_pkg::GND_CH*8-1:0]             GND_POLL_CURRENT,
	output logic [lpmcfg_pkg::PROG_CH-1:0]              PROG_POLL_STROBE,
	output logic [lpmcfg_pkg::GND_CH-1:0]               GND_POLL_STROBE
);

	localparam int PCH = lpmcfg_pkg::PROG_CH;
	localparam int GCH = lpmcfg_pkg::GND_CH;
	localparam int CW  = lpmcfg_pkg::CUR_W;
	localparam int WW  = lpmcfg_pkg::WET_CODE_W;

	typedef struct packed {
		logic [2:0]                sync;
		lpmcfg_pkg::lpmcfg_state_t state;
		logic [PCH-1:0]            cur_prog;
		logic [GCH-1:0]            cur_gnd;
		logic [PCH-1:0]            slow_prog;
		logic [31:0]               reply;
		logic [1:0]                slow_cnt;
		logic [PCH*CW-1:0]         prog_cur;
		logic [GCH*CW-1:0]         gnd_cur;
		logic [PCH-1:0]            prog_stb;
		logic [GCH-1:0]            gnd_stb;
	} lpmcfg_core_t;

	localparam lpmcfg_core_t CORE_RST = '{
		sync:      3'h0,
		state:     lpmcfg_pkg::LPMCFG_IDLE,
		cur_prog:  lpmcfg_pkg::RST_POLL_CUR_PROG,
		cur_gnd:   lpmcfg_pkg::RST_POLL_CUR_GND,
		slow_prog: lpmcfg_pkg::RST_SLOW_POLL_PROG,
		reply:     32'h0000_0000,
		slow_cnt:  2'h0,
		prog_cur:  '0,
		gnd_cur:   '0,
		prog_stb:  '0,
		gnd_stb:   '0
	};

	lpmcfg_core_t s_q;
	lpmcfg_core_t s_d;
	lpmcfg_if     link_bus ();

	// ==========================================================
	// Serial link end on its own clock
	lpmcfg_spi_link u_link
	(
		.sclk    (SCLK),
		.rst     (RST),
		.cs_n    (CS_B),
		.mosi    (MOSI),
		.miso    (MISO),
		.miso_oe (MISO_OE),
		.bus     (link_bus.link)
	);

	assign link_bus.reply = s_q.reply;

	// ==========================================================
	// Register read decoder, shared by reads and write replies.
	function automatic logic [21:0] reg_read(
		input logic [6:0]     addr,
		input lpmcfg_core_t   s
	);
		case (addr)
			lpmcfg_pkg::ADDR_POLL_CUR_PROG:  reg_read = {14'h0000, s.cur_prog};
			lpmcfg_pkg::ADDR_POLL_CUR_GND:   reg_read = {8'h00, s.cur_gnd};
			lpmcfg_pkg::ADDR_SLOW_POLL_PROG: reg_read = {14'h0000, s.slow_prog};
			default:                         reg_read = 22'h00_0000;
		endcase
	endfunction : reg_read

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic        req;
		logic [6:0]  addr;
		logic        rw;
		logic [23:0] wdata;
		logic        tick;
		logic        slow_go;
		req     = 1'b0;
		addr    = 7'h00;
		rw      = 1'b0;
		wdata   = 24'h00_0000;
		tick    = 1'b0;
		slow_go = 1'b0;

		s_d      = s_q;
		s_d.sync = {s_q.sync[1:0], link_bus.req_tgl};
		req      = s_q.sync[2] ^ s_q.sync[1];
		addr     = link_bus.frame[lpmcfg_pkg::ADDR_MSB:lpmcfg_pkg::ADDR_LSB];
		rw       = link_bus.frame[lpmcfg_pkg::RW_BIT];
		wdata    = link_bus.frame[lpmcfg_pkg::DATA_MSB:0];

		// Frame execution: a write stores, a read leaves the register unchanged.
		case (s_q.state)
			lpmcfg_pkg::LPMCFG_IDLE:
			begin
				if (req)
					s_d.state = lpmcfg_pkg::LPMCFG_EXEC;
			end
			lpmcfg_pkg::LPMCFG_EXEC:
			begin
				if (rw == lpmcfg_pkg::RW_WRITE)
				begin
					case (addr)
						lpmcfg_pkg::ADDR_POLL_CUR_PROG:
							s_d.cur_prog = wdata[PCH-1:0];
						lpmcfg_pkg::ADDR_POLL_CUR_GND:
							s_d.cur_gnd = wdata[GCH-1:0];
						lpmcfg_pkg::ADDR_SLOW_POLL_PROG:
							s_d.slow_prog = wdata[PCH-1:0];
						default:
							s_d.cur_prog = s_q.cur_prog;
					endcase
				end
				s_d.reply = {addr, rw, FAULT_STATUS, INTERRUPT_FLAG, reg_read(addr, s_d)};
				s_d.state = lpmcfg_pkg::LPMCFG_IDLE;
			end
			default:
				s_d.state = lpmcfg_pkg::LPMCFG_IDLE;
		endcase

		// Slow polling phase counter advances on each normal tick in low-power state.
		tick = LOW_POWER_STATE & NORMAL_POLL_TICK;
		if (!LOW_POWER_STATE)
			s_d.slow_cnt = lpmcfg_pkg::SLOW_PHASE;
		else if (tick)
			s_d.slow_cnt = s_q.slow_cnt + 2'h1;
		slow_go = tick & (s_q.slow_cnt == lpmcfg_pkg::SLOW_PHASE);

		// Programmable channels: current choice and polling strobes.
		for (int i = 0; i < PCH; i++)
		begin
			if (s_q.cur_prog[i])
				s_d.prog_cur[i*CW +: CW] =
					lpmcfg_pkg::wet_units(WETTING_LEVEL_PROG[i*WW +: WW]);
			else if (BATTERY_SWITCH_CONFIG[i])
				s_d.prog_cur[i*CW +: CW] = lpmcfg_pkg::CUR_DEFAULT_BATT;
			else
				s_d.prog_cur[i*CW +: CW] = lpmcfg_pkg::CUR_DEFAULT_GND;
			if (s_q.slow_prog[i])
				s_d.prog_stb[i] = slow_go;
			else
				s_d.prog_stb[i] = tick;
		end

		// Ground-switch channels: current choice, polled on every tick.
		for (int j = 0; j < GCH; j++)
		begin
			if (s_q.cur_gnd[j])
				s_d.gnd_cur[j*CW +: CW] =
					lpmcfg_pkg::wet_units(WETTING_LEVEL_GND[j*WW +: WW]);
			else
				s_d.gnd_cur[j*CW +: CW] = lpmcfg_pkg::CUR_DEFAULT_GND;
			s_d.gnd_stb[j] = tick;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			s_q <= CORE_RST;
		else
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs
	assign PROG_POLL_CURRENT = s_q.prog_cur;
	assign GND_POLL_CURRENT  = s_q.gnd_cur;
	assign PROG_POLL_STROBE  = s_q.prog_stb;
	assign GND_POLL_STROBE   = s_q.gnd_stb;

endmodule : lpmcfg_regs

// *** lpmcfg_asserts.sv ***
// Port checker of the low-power polling configuration block.
module lpmcfg_asserts
(
	input wire logic                                 CLOCK,
	input wire logic                                 RST,
	input wire logic                                 CS_B,
	input wire logic                                 MISO_OE,
	input wire logic                                 LOW_POWER_STATE,
	input wire logic                                 NORMAL_POLL_TICK,
	input wire logic [lpmcfg_pkg::PROG_CH-1:0]       BATTERY_SWITCH_CONFIG,
	input wire logic [lpmcfg_pkg::PROG_CH*3-1:0]     WETTING_LEVEL_PROG,
	input wire logic [lpmcfg_pkg::GND_CH*3-1:0]      WETTING_LEVEL_GND,
	input wire logic [lpmcfg_pkg::PROG_CH*8-1:0]     PROG_POLL_CURRENT,
	input wire logic [lpmcfg_pkg::GND_CH*8-1:0]      GND_POLL_CURRENT,
	input wire logic [lpmcfg_pkg::PROG_CH-1:0]       PROG_POLL_STROBE,
	input wire logic [lpmcfg_pkg::GND_CH-1:0]        GND_POLL_STROBE
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	// ==========================================================
	// Properties.
	property p_oe;
		MISO_OE == !CS_B;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable not following select");
	property p_gnd_tick;
		LOW_POWER_STATE && NORMAL_POLL_TICK |=> &GND_POLL_STROBE;
	endproperty
	a_gnd_tick: assert property (p_gnd_tick) else $error("ground strobe missing");
	property p_gnd_cause;
		GND_POLL_STROBE != 0 |-> $past(LOW_POWER_STATE && NORMAL_POLL_TICK);
	endproperty
	a_gnd_cause: assert property (p_gnd_cause) else $error("ground strobe without tick");
	property p_prog_sub;
		PROG_POLL_STROBE != 0 |-> &GND_POLL_STROBE;
	endproperty
	a_prog_sub: assert property (p_prog_sub) else $error("channel strobe off tick");
	property p_batt;
		PROG_POLL_CURRENT[7:0] == 8'h16 |-> $past(BATTERY_SWITCH_CONFIG[0]);
	endproperty
	a_batt: assert property (p_batt) else $error("battery default on wrong channel");
	property p_gsw;
		PROG_POLL_CURRENT[63:56] == 8'h0A |-> !$past(BATTERY_SWITCH_CONFIG[7]);
	endproperty
	a_gsw: assert property (p_gsw) else $error("ground default on wrong channel");
	property p_wet_prog;
		PROG_POLL_CURRENT[63:56] == 8'hC8 |-> $past(WETTING_LEVEL_PROG[23:21]) == 3'h7;
	endproperty
	a_wet_prog: assert property (p_wet_prog) else $error("wetting current mismatch");
	property p_gnd_cur;
		!$past(RST) && $past(WETTING_LEVEL_GND[2:0]) == 3'h7
			|-> GND_POLL_CURRENT[7:0] inside {8'h0A, 8'hC8};
	endproperty
	a_gnd_cur: assert property (p_gnd_cur) else $error("ground current illegal");
endmodule : lpmcfg_asserts

// *** lpmcfg_spi_master.sv ***
// Serial master model that frames 32-bit words for the register block.
module lpmcfg_spi_master
(
	output logic      SCLK,
	output logic      CS_B,
	output logic      MOSI,
	input  wire logic MISO
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		SCLK = 1'b0;
		CS_B = 1'b1;
		MOSI = 1'b0;
	end
	// Shifts a frame out first bit high and collects the reply in the low phase.
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		#3.1 CS_B = 1'b0;
		for (int k = 31; k >= 0; k--)
		begin
			MOSI = tx[k];
			#7.5 rx[k] = MISO;
			SCLK = 1'b1;
			#7.5 SCLK = 1'b0;
		end
		#7.5 CS_B = 1'b1;
		MOSI = ~MOSI;
	endtask : xfer
endmodule : lpmcfg_spi_master

// *** lpmcfg_regs_tb.sv ***
// Self-checking bench of the low-power polling configuration block.
module lpmcfg_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic         CLOCK, RST, SCLK, CS_B, MOSI, MISO, MISO_OE, FAULT_STATUS, INTERRUPT_FLAG;
	logic         LOW_POWER_STATE, NORMAL_POLL_TICK;
	logic [7:0]   BATTERY_SWITCH_CONFIG, PROG_POLL_STROBE;
	logic [23:0]  WETTING_LEVEL_PROG;
	logic [41:0]  WETTING_LEVEL_GND;
	logic [63:0]  PROG_POLL_CURRENT;
	logic [111:0] GND_POLL_CURRENT;
	logic [13:0]  GND_POLL_STROBE;
	logic [31:0]  rx;
	int           errors, tests_run, n_slow, n_fast, n_gnd;
	localparam logic [7:0] WET [8] = '{8'h14, 8'h3C, 8'h50, 8'h64, 8'h78, 8'h8C, 8'hA0, 8'hC8};
	lpmcfg_regs i_dut (.CLOCK(CLOCK), .RST(RST), .SCLK(SCLK), .CS_B(CS_B), .MOSI(MOSI),
		.MISO(MISO), .MISO_OE(MISO_OE), .FAULT_STATUS(FAULT_STATUS),
		.INTERRUPT_FLAG(INTERRUPT_FLAG), .LOW_POWER_STATE(LOW_POWER_STATE),
		.NORMAL_POLL_TICK(NORMAL_POLL_TICK), .BATTERY_SWITCH_CONFIG(BATTERY_SWITCH_CONFIG),
		.WETTING_LEVEL_PROG(WETTING_LEVEL_PROG), .WETTING_LEVEL_GND(WETTING_LEVEL_GND),
		.PROG_POLL_CURRENT(PROG_POLL_CURRENT), .GND_POLL_CURRENT(GND_POLL_CURRENT),
		.PROG_POLL_STROBE(PROG_POLL_STROBE), .GND_POLL_STROBE(GND_POLL_STROBE));
	lpmcfg_spi_master i_master (.SCLK(SCLK), .CS_B(CS_B), .MOSI(MOSI), .MISO(MISO));
	initial
	begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK)
	begin
		n_slow += PROG_POLL_STROBE[0];
		n_fast += PROG_POLL_STROBE[1];
		n_gnd += GND_POLL_STROBE[13];
	end
	// ==========================================================
	// Shared tasks.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task automatic fr(input logic [6:0] a, input logic w, input logic [23:0] d);
		i_master.xfer({a, w, d}, rx);
		repeat (10) @(posedge CLOCK);
	endtask : fr
	task automatic cur_chk(input bit wet);
		logic [31:0] ep;
		logic [31:0] eg;
		for (int i = 0; i < 14; i++)
		begin
			ep = (i < 4) ? 32'h0000_0016 : 32'h0000_000A;
			eg = wet ? 32'h0000_00C8 : 32'h0000_000A;
			if (wet && i < 8)
				ep = 32'(WET[i]);
			if (i < 8)
				chk(32'(PROG_POLL_CURRENT[8*i+:8]), ep, "prog current");
			chk(32'(GND_POLL_CURRENT[8*i+:8]), eg, "gnd current");
		end
	endtask : cur_chk
	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		logic [6:0] a [4];
		a = '{7'h16, 7'h17, 7'h18, 7'h18};
		FAULT_STATUS <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			fr(a[i], 1'b0, 24'h00_0000);
			if (i > 0) chk(rx, {a[i-1], 3'b010, 22'h0}, "reset value");
		end
	endtask : t_reset
	task automatic t_rw();
		logic [6:0]  a [4];
		logic [21:0] m [4];
		a = '{7'h16, 7'h17, 7'h18, 7'h19};
		m = '{22'h00_00FF, 22'h00_3FFF, 22'h00_00FF, 22'h00_0000};
		FAULT_STATUS <= 1'b0;
		INTERRUPT_FLAG <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			fr(a[i], 1'b1, 24'hFF_FFFF);
			fr(a[i], 1'b0, 24'h00_0000);
			chk(rx, {a[i], 3'b101, m[i]}, "write reply");
			fr(a[i], 1'b0, 24'h00_0000);
			chk(rx, {a[i], 3'b001, m[i]}, "read reply");
		end
	endtask : t_rw
	task automatic t_cur();
		cur_chk(1'b1);
		fr(7'h16, 1'b1, 24'h00_0000);
		fr(7'h17, 1'b1, 24'h00_0000);
		cur_chk(1'b0);
	endtask : t_cur
	task automatic t_rst_mid();
		RST <= 1'b1;
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		fr(7'h18, 1'b0, 24'h00_0000);
		chk(rx, 32'h0000_0000, "reply after reset");
		fr(7'h16, 1'b0, 24'h00_0000);
		chk(rx, {7'h18, 3'b001, 22'h00_0000}, "slow register after reset");
	endtask : t_rst_mid
	task automatic t_poll();
		fr(7'h18, 1'b1, 24'h00_0001);
		LOW_POWER_STATE <= 1'b1;
		#1 n_slow = 0;
		n_fast = 0;
		n_gnd = 0;
		for (int i = 0; i < 10; i++)
		begin
			if (i == 8) LOW_POWER_STATE <= 1'b0;
			@(posedge CLOCK) NORMAL_POLL_TICK <= 1'b1;
			@(posedge CLOCK) NORMAL_POLL_TICK <= 1'b0;
		end
		repeat (3) @(posedge CLOCK);
		chk(32'(n_slow), 32'h0000_0002, "slow strobes");
		chk(32'(n_fast), 32'h0000_0008, "normal strobes");
		chk(32'(n_gnd), 32'h0000_0008, "ground strobes");
	endtask : t_poll
	task automatic conclude();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	initial
	begin
		RST = 1'b1;
		{FAULT_STATUS, INTERRUPT_FLAG, LOW_POWER_STATE, NORMAL_POLL_TICK} = 4'h0;
		BATTERY_SWITCH_CONFIG = 8'h0F;
		WETTING_LEVEL_PROG = 24'hFA_C688;
		WETTING_LEVEL_GND = 42'h3FF_FFFF_FFFF;
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		t_reset();
		t_rw();
		t_cur();
		t_rst_mid();
		t_poll();
		conclude();
	end
	initial
	begin
		#200000;
		errors++;
		conclude();
	end
endmodule : lpmcfg_regs_tb
bind lpmcfg_regs lpmcfg_asserts i_chk (.CLOCK(CLOCK), .RST(RST), .CS_B(CS_B), .MISO_OE(MISO_OE),
	.LOW_POWER_STATE(LOW_POWER_STATE), .NORMAL_POLL_TICK(NORMAL_POLL_TICK),
	.BATTERY_SWITCH_CONFIG(BATTERY_SWITCH_CONFIG), .WETTING_LEVEL_PROG(WETTING_LEVEL_PROG),
	.WETTING_LEVEL_GND(WETTING_LEVEL_GND), .PROG_POLL_CURRENT(PROG_POLL_CURRENT),
	.GND_POLL_CURRENT(GND_POLL_CURRENT), .PROG_POLL_STROBE(PROG_POLL_STROBE),
	.GND_POLL_STROBE(GND_POLL_STROBE));
